//--- plpc_fts_sender.sv
/*
 * Presents the required FTS count to the training-set builder at link init.
 * Assumes init_req is a one-cycle pulse on the core clock.
 */
`timescale 1ns/100ps
module plpc_fts_sender (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclken,
    plpc_if.fts bus
);
    typedef struct packed {
        logic [7:0] nfts;
        logic valid;
    } plpc_fts_state_t;

    plpc_fts_state_t s;
    plpc_fts_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.valid = bus.init_req;
        if (bus.init_req) begin
            // Captured so a later config write cannot change a training set in flight
            next_s.nfts = bus.nfts_cfg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '{nfts: '0, valid: 1'b0};
        end else if (aclken) begin
            s <= next_s;
        end
    end

    assign bus.nfts_tx = s.nfts;
    assign bus.nfts_tx_valid = s.valid;
endmodule // plpc_fts_sender

//--- plpc_idle_timer.sv
/*
 * L0s entry timer: counts uninterrupted transmit idle time in ns.
 * Assumes thr_steps and tx_busy come from logic on the same clock.
 */
`timescale 1ns/100ps
module plpc_idle_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclken,
    plpc_if.timer bus
);
    typedef struct packed {
        plpc_pkg::plpc_idle_state_t state;
        logic [13:0] acc;
    } plpc_timer_state_t;

    plpc_timer_state_t s;
    plpc_timer_state_t next_s;
    logic [13:0] thr_ns;
    logic [13:0] acc_inc;

    always_comb begin
        next_s = s;
        thr_ns = (14'(bus.thr_steps) + 14'h1) << plpc_pkg::L0S_STEP_SHIFT;
        acc_inc = s.acc + plpc_pkg::CLK_PERIOD_ACC;
        case (s.state)
            plpc_pkg::IDLE_BUSY: begin
                next_s.acc = '0;
                if (!bus.tx_busy) begin
                    next_s.state = plpc_pkg::IDLE_COUNT;
                end
            end
            plpc_pkg::IDLE_COUNT: begin
                if (bus.tx_busy) begin
                    // Any traffic restarts the idle interval from zero
                    next_s.state = plpc_pkg::IDLE_BUSY;
                    next_s.acc = '0;
                end else if (acc_inc >= thr_ns) begin
                    next_s.state = plpc_pkg::IDLE_L0S;
                end else begin
                    next_s.acc = acc_inc;
                end
            end
            plpc_pkg::IDLE_L0S: begin
                if (bus.tx_busy) begin
                    next_s.state = plpc_pkg::IDLE_BUSY;
                    next_s.acc = '0;
                end
            end
            default: begin
                next_s.state = plpc_pkg::IDLE_BUSY;
                next_s.acc = '0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '{state: plpc_pkg::IDLE_BUSY, acc: '0};
        end else if (aclken) begin
            s <= next_s;
        end
    end

    assign bus.in_l0s = (s.state == plpc_pkg::IDLE_L0S);
endmodule // plpc_idle_timer

//--- plpc_if.sv
/*
 * Carrier between the configuration core and its timer and FTS sender.
 * Assumes all three modules share one clock.
 */
`timescale 1ns/100ps
interface plpc_if;
    logic [4:0] thr_steps;
    logic tx_busy;
    logic in_l0s;
    logic [7:0] nfts_cfg;
    logic init_req;
    logic [7:0] nfts_tx;
    logic nfts_tx_valid;

    modport core (
        output thr_steps, tx_busy, nfts_cfg, init_req,
        input in_l0s, nfts_tx, nfts_tx_valid
    );
    modport timer (input thr_steps, tx_busy, output in_l0s);
    modport fts (input nfts_cfg, init_req, output nfts_tx, nfts_tx_valid);
endinterface // plpc_if

//--- plpc_link_partner.sv
/*
 * Link partner stand-in: takes the FTS count, makes per-VC receive activity.
 * Assumes the core clock; the activity pattern comes from the bench.
 */
`timescale 1ns/100ps
module plpc_link_partner (
    input wire logic aclk,
    input wire logic [7:0] cfg_nfts,
    input wire logic cfg_nfts_valid,
    input wire logic [1:0] rx_pat,
    output logic [1:0] rx_active_vc,
    output logic [7:0] nfts_seen
);
    always_ff @(posedge aclk) begin
        rx_active_vc <= rx_pat;
        if (cfg_nfts_valid) begin
            nfts_seen <= cfg_nfts;
        end
    end
endmodule // plpc_link_partner

//--- plpc_pkg.sv
/*
 * Constants and shared types of the link power configuration block.
 * Assumes a single core clock; the idle timer, the top and the bench refer to names here.
 */
package plpc_pkg;
    // Clock rate and derived period
    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int unsigned NUM_VC = 2;

    // L0s idle threshold: steps of 256 ns, 256 ns to 8192 ns
    localparam int unsigned L0S_STEP_NS = 256;
    localparam int unsigned L0S_MAX_NS = 8192;
    localparam int unsigned L0S_STEP_SHIFT = 8;
    localparam int unsigned ACC_W = 14;
    localparam logic [13:0] CLK_PERIOD_ACC = 14'(CLK_PERIOD_NS);
    localparam logic [4:0] L0S_STEP_MAX = 5'(L0S_MAX_NS / L0S_STEP_NS - 1);

    // One fast training sequence lasts four symbols of 4 ns
    localparam int unsigned FTS_NS = 16;
    localparam logic [7:0] NFTS_MAX = 8'hff;
    localparam logic [2:0] LAT_MAX = 3'h7;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_IDLE = 8'h04;
    localparam logic [7:0] ADDR_NFTS = 8'h08;
    localparam logic [7:0] ADDR_LAT = 8'h0c;
    localparam logic [7:0] ADDR_DEVCAP = 8'h10;
    localparam logic [7:0] ADDR_LINKCAP = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    // Control fields
    localparam int unsigned CTRL_COMMON_BIT = 0;
    localparam int unsigned CTRL_XCVR_BIT = 1;
    localparam int unsigned CTRL_L1EN_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h1;
    localparam logic [4:0] IDLE_RST = 5'h1b;
    localparam logic [7:0] NFTS_COMMON_RST = 8'hff;
    localparam logic [7:0] NFTS_SEP_RST = 8'hff;
    localparam int unsigned NFTS_SEP_LSB = 8;

    // Latency configuration fields
    localparam int unsigned LAT_L0SACC_LSB = 0;
    localparam int unsigned LAT_L1ACC_LSB = 4;
    localparam int unsigned LAT_L1EXC_LSB = 8;
    localparam int unsigned LAT_L1EXS_LSB = 12;
    localparam logic [15:0] LAT_RST = 16'h0000;

    // Capability field positions
    localparam int unsigned DEVCAP_L0SACC_LSB = 6;
    localparam int unsigned DEVCAP_L1ACC_LSB = 9;
    localparam int unsigned LINKCAP_ASPM_LSB = 10;
    localparam int unsigned LINKCAP_L0SEXIT_LSB = 12;
    localparam int unsigned LINKCAP_L1EXIT_LSB = 15;

    // Status fields
    localparam int unsigned STAT_L0S_BIT = 0;
    localparam int unsigned STAT_RX_LSB = 8;
    localparam int unsigned STAT_TX_LSB = 16;
    localparam int unsigned STAT_NFTS_LSB = 24;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        IDLE_BUSY = 2'h0,
        IDLE_COUNT = 2'h1,
        IDLE_L0S = 2'h3
    } plpc_idle_state_t;
endpackage

//--- plpc_top.sv
/*
 * Active-state link power configuration of an endpoint: AXI4-Lite registers,
 * capability field derivation, L0s idle timer and FTS count hand-off.
 * Assumes traffic and link-init inputs come from logic on aclk.
 */
// Summary of operation
// - The transmitter enters L0s after the link idles for a threshold of 256 ns to 8192 ns.
// - The device capabilities show the configured L0s acceptable latency read-only.
// - The device capabilities show the configured L1 acceptable latency read-only.
// - In common clock mode the common FTS count (0-255) is sent at link init.
// - In separate clock mode the separate FTS count is sent and sets the L0s exit latency.
// - The link capabilities L1 support bit follows the L1 ASPM enable.
// - The L1 exit latency field comes from the exit latency of the active clock mode.
// - The integrated transceiver forces threshold, FTS and L1 exit to maximum, L1 off.
// - Transmit busy and receive active exist per virtual channel; tx_l0s, config and global are shared.
// - The application interface has transmit, receive, configuration and global groups.
`timescale 1ns/100ps
module plpc_top (
    // Global group
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclken,
    input wire logic gbl_link_init,
    // Register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Transmit group, one busy per virtual channel
    input wire logic [1:0] tx_busy_vc,
    output logic tx_l0s,
    // Receive group, one active per virtual channel
    input wire logic [1:0] rx_active_vc,
    // Configuration group
    output logic [31:0] cfg_devcap,
    output logic [31:0] cfg_linkcap,
    output logic [7:0] cfg_nfts,
    output logic cfg_nfts_valid
);
    typedef struct packed {
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [2:0] ctrl;
        logic [4:0] idle;
        logic [15:0] nfts;
        logic [15:0] lat;
        logic [31:0] devcap;
        logic [31:0] linkcap;
    } plpc_top_state_t;

    localparam plpc_top_state_t TOP_RST = '{
        ctrl: plpc_pkg::CTRL_RST,
        idle: plpc_pkg::IDLE_RST,
        nfts: {plpc_pkg::NFTS_SEP_RST, plpc_pkg::NFTS_COMMON_RST},
        lat: plpc_pkg::LAT_RST,
        default: '0
    };

    plpc_top_state_t s;
    plpc_top_state_t next_s;
    plpc_if link_if ();

    // Byte-lane merge for a register write
    function automatic logic [31:0] plpc_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Answer for an address: read-only words refuse writes
    function automatic logic [1:0] plpc_resp(input logic [7:0] addr, input logic is_wr);
        logic [1:0] r;
        r = plpc_pkg::RESP_DECERR;
        case (addr)
            plpc_pkg::ADDR_CTRL, plpc_pkg::ADDR_IDLE,
            plpc_pkg::ADDR_NFTS, plpc_pkg::ADDR_LAT: begin
                r = plpc_pkg::RESP_OKAY;
            end
            plpc_pkg::ADDR_DEVCAP, plpc_pkg::ADDR_LINKCAP,
            plpc_pkg::ADDR_STATUS: begin
                r = is_wr ? plpc_pkg::RESP_SLVERR : plpc_pkg::RESP_OKAY;
            end
            default: begin
                r = plpc_pkg::RESP_DECERR;
            end
        endcase
        return r;
    endfunction

    // L0s exit time is the FTS count times one FTS, coded in power-of-two bands
    function automatic logic [2:0] plpc_l0s_exit(input logic [7:0] n);
        logic [12:0] t;
        logic [2:0] code;
        t = 13'(n) * 13'(plpc_pkg::FTS_NS);
        if (t < 13'd64) code = 3'h0;
        else if (t < 13'd128) code = 3'h1;
        else if (t < 13'd256) code = 3'h2;
        else if (t < 13'd512) code = 3'h3;
        else if (t < 13'd1024) code = 3'h4;
        else if (t < 13'd2048) code = 3'h5;
        else if (t < 13'd4096) code = 3'h6;
        else code = 3'h7;
        return code;
    endfunction

    logic xcvr;
    logic common_clk;
    logic [4:0] eff_thr;
    logic [7:0] eff_nfts_c;
    logic [7:0] eff_nfts_s;
    logic [7:0] eff_nfts;
    logic [2:0] eff_l1exit;
    logic l1_sup;
    logic [1:0] vc_busy;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic aw_ok;
    logic w_ok;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] status;

    // Transmit traffic of every virtual channel keeps the shared link busy
    for (genvar v = 0; v < plpc_pkg::NUM_VC; v++) begin : g_vc
        assign vc_busy[v] = tx_busy_vc[v];
    end

    always_comb begin
        xcvr = s.ctrl[plpc_pkg::CTRL_XCVR_BIT];
        common_clk = s.ctrl[plpc_pkg::CTRL_COMMON_BIT];
        eff_thr = xcvr ? plpc_pkg::L0S_STEP_MAX : s.idle;
        eff_nfts_c = xcvr ? plpc_pkg::NFTS_MAX : s.nfts[7:0];
        eff_nfts_s = xcvr ? plpc_pkg::NFTS_MAX : s.nfts[plpc_pkg::NFTS_SEP_LSB +: 8];
        eff_nfts = common_clk ? eff_nfts_c : eff_nfts_s;
        if (xcvr) begin
            eff_l1exit = plpc_pkg::LAT_MAX;
        end else if (common_clk) begin
            eff_l1exit = s.lat[plpc_pkg::LAT_L1EXC_LSB +: 3];
        end else begin
            eff_l1exit = s.lat[plpc_pkg::LAT_L1EXS_LSB +: 3];
        end
        // Transceiver has no L1 support, whatever software asks
        l1_sup = s.ctrl[plpc_pkg::CTRL_L1EN_BIT] & ~xcvr;
        status = '0;
        status[plpc_pkg::STAT_L0S_BIT] = link_if.in_l0s;
        status[plpc_pkg::STAT_RX_LSB +: 2] = rx_active_vc;
        status[plpc_pkg::STAT_TX_LSB +: 2] = vc_busy;
        status[plpc_pkg::STAT_NFTS_LSB +: 8] = eff_nfts;
    end

    assign link_if.thr_steps = eff_thr;
    assign link_if.tx_busy = |vc_busy;
    assign link_if.nfts_cfg = eff_nfts;
    assign link_if.init_req = gbl_link_init;

    // Ready is withheld while frozen so no handshake completes without a state update
    assign s_axi_awready = aclken & ~s.aw_have & ~s.bvalid;
    assign s_axi_wready = aclken & ~s.w_have & ~s.bvalid;
    assign s_axi_arready = aclken & ~s.rvalid;
    assign aw_fire = s_axi_awvalid & s_axi_awready;
    assign w_fire = s_axi_wvalid & s_axi_wready;
    assign ar_fire = s_axi_arvalid & s_axi_arready;
    assign aw_ok = s.aw_have | aw_fire;
    assign w_ok = s.w_have | w_fire;
    assign wr_addr = s.aw_have ? s.awaddr : s_axi_awaddr;
    assign wr_data = s.w_have ? s.wdata : s_axi_wdata;
    assign wr_strb = s.w_have ? s.wstrb : s_axi_wstrb;

    always_comb begin
        next_s = s;
        // Write address and data may arrive in either order
        if (aw_fire) begin
            next_s.aw_have = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (w_fire) begin
            next_s.w_have = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (aw_ok && w_ok) begin
            next_s.aw_have = 1'b0;
            next_s.w_have = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = plpc_resp(wr_addr, 1'b1);
            case (wr_addr)
                plpc_pkg::ADDR_CTRL: begin
                    next_s.ctrl = 3'(plpc_merge(32'(s.ctrl), wr_data, wr_strb));
                end
                plpc_pkg::ADDR_IDLE: begin
                    next_s.idle = 5'(plpc_merge(32'(s.idle), wr_data, wr_strb));
                end
                plpc_pkg::ADDR_NFTS: begin
                    next_s.nfts = 16'(plpc_merge(32'(s.nfts), wr_data, wr_strb));
                end
                plpc_pkg::ADDR_LAT: begin
                    next_s.lat = 16'(plpc_merge(32'(s.lat), wr_data, wr_strb));
                end
                default: begin
                    next_s.bvalid = 1'b1;
                end
            endcase
        end else if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        if (ar_fire) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = plpc_resp(s_axi_araddr, 1'b0);
            case (s_axi_araddr)
                plpc_pkg::ADDR_CTRL: next_s.rdata = 32'(s.ctrl);
                plpc_pkg::ADDR_IDLE: next_s.rdata = 32'(s.idle);
                plpc_pkg::ADDR_NFTS: next_s.rdata = 32'(s.nfts);
                plpc_pkg::ADDR_LAT: next_s.rdata = 32'(s.lat);
                plpc_pkg::ADDR_DEVCAP: next_s.rdata = s.devcap;
                plpc_pkg::ADDR_LINKCAP: next_s.rdata = s.linkcap;
                plpc_pkg::ADDR_STATUS: next_s.rdata = status;
                default: next_s.rdata = '0;
            endcase
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end

        next_s.devcap = '0;
        next_s.devcap[plpc_pkg::DEVCAP_L0SACC_LSB +: 3] =
            s.lat[plpc_pkg::LAT_L0SACC_LSB +: 3];
        next_s.devcap[plpc_pkg::DEVCAP_L1ACC_LSB +: 3] =
            s.lat[plpc_pkg::LAT_L1ACC_LSB +: 3];
        next_s.linkcap = '0;
        // L0s is always supported; L1 only when enabled
        next_s.linkcap[plpc_pkg::LINKCAP_ASPM_LSB +: 2] = {l1_sup, 1'b1};
        next_s.linkcap[plpc_pkg::LINKCAP_L0SEXIT_LSB +: 3] = plpc_l0s_exit(eff_nfts);
        next_s.linkcap[plpc_pkg::LINKCAP_L1EXIT_LSB +: 3] = eff_l1exit;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= TOP_RST;
        end else if (aclken) begin
            s <= next_s;
        end
    end

    plpc_idle_timer u_idle_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .aclken(aclken),
        .bus(link_if.timer)
    );

    plpc_fts_sender u_fts_sender (
        .aclk(aclk),
        .aresetn(aresetn),
        .aclken(aclken),
        .bus(link_if.fts)
    );

    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign tx_l0s = link_if.in_l0s;
    // Four application groups: transmit, receive, configuration, global
    assign cfg_devcap = s.devcap;
    assign cfg_linkcap = s.linkcap;
    assign cfg_nfts = link_if.nfts_tx;
    assign cfg_nfts_valid = link_if.nfts_tx_valid;
endmodule // plpc_top

//--- plpc_top_chk.sv
/*
 * Concurrent checks on the ports of the link power configuration top.
 * Assumes one core clock; bound into plpc_top at the foot of this file.
 */
`timescale 1ns/100ps
module plpc_top_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclken,
    input wire logic gbl_link_init,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] tx_busy_vc,
    input wire logic tx_l0s,
    input wire logic [31:0] cfg_linkcap,
    input wire logic [7:0] cfg_nfts,
    input wire logic cfg_nfts_valid
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Enabled idle edges since the last busy sample, saturating
    logic [7:0] idle_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn || (aclken && |tx_busy_vc)) begin
            idle_cnt <= 8'h00;
        end else if (aclken && idle_cnt != 8'hff) begin
            idle_cnt <= idle_cnt + 8'h01;
        end
    end

    function automatic logic [2:0] ecode(logic [7:0] k);
        ecode = 3'h0;
        for (int i = 2; i < 8; i++) begin
            if (k[i]) begin
                ecode = 3'(i - 1);
            end
        end
    endfunction

    property p_l0s_min; $rose(tx_l0s) |-> idle_cnt >= 8'h08; endproperty
    a_l0s_min: assert property (p_l0s_min) else $error("early low-power entry");
    property p_l0s_max; idle_cnt >= 8'hce |-> tx_l0s; endproperty
    a_l0s_max: assert property (p_l0s_max) else $error("late low-power entry");
    property p_l0s_hold; tx_l0s && !(aclken && |tx_busy_vc) |=> tx_l0s; endproperty
    a_l0s_hold: assert property (p_l0s_hold) else $error("low-power left while idle");
    property p_l0s_exit; tx_l0s && aclken && |tx_busy_vc |=> !tx_l0s; endproperty
    a_l0s_exit: assert property (p_l0s_exit) else $error("low-power kept under traffic");
    property p_init; gbl_link_init && aclken |=> cfg_nfts_valid; endproperty
    a_init: assert property (p_init) else $error("count not sent at init");
    property p_code; cfg_nfts_valid |-> cfg_linkcap[14:12] == ecode(cfg_nfts); endproperty
    a_code: assert property (p_code) else $error("exit field off sent count");
    property p_lcap; $past(aresetn, 3) |-> cfg_linkcap[10]; endproperty
    a_lcap: assert property (p_lcap) else $error("short-exit support bit clear");
    property p_b; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
    endproperty
    a_b: assert property (p_b) else $error("write response missing");
    property p_r; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r: assert property (p_r) else $error("read data missing");
    property p_rblk; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rblk: assert property (p_rblk) else $error("read taken while busy");
    property p_clk; !aclken |-> !(s_axi_awready || s_axi_wready || s_axi_arready); endproperty
    a_clk: assert property (p_clk) else $error("ready while disabled");

    c_l0s: cover property ($rose(tx_l0s));
    c_init: cover property (cfg_nfts_valid);
    c_err: cover property (s_axi_bvalid && s_axi_bresp != 2'h0);
endmodule // plpc_top_chk

bind plpc_top plpc_top_chk i_plpc_top_chk (.*);

//--- test_pcie_aspm_link_power_config.sv
/*
 * Self-checking bench: drivers queue expected results, a monitor compares.
 * Assumes plpc_top, the partner model and the bound checker.
 */
`timescale 1ns/100ps
module test_pcie_aspm_link_power_config;
    logic aclk = 1'h0, aresetn = 1'h0, aclken = 1'h1, gbl_link_init = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] tx_busy_vc = 2'h0, rx_pat = 2'h0, rx_active_vc, s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tx_l0s, cfg_nfts_valid;
    logic [31:0] s_axi_rdata, cfg_devcap, cfg_linkcap;
    logic [7:0] cfg_nfts, nfts_seen, eff;
    logic [2:0] c;
    logic [15:0] n, l;
    logic [4:0] v;
    int mismatches = 0;
    int comparisons = 0;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [7:0] nq[$];

    plpc_top i_plpc_top (.*);
    plpc_link_partner i_plpc_link_partner (.*);

    always #20 aclk = ~aclk;

    task automatic chk(string nm, logic [33:0] seen, logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("Counts: %0d compares, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic tmo();
        chk("handshake", 34'h0, 34'h1);
        report_and_stop();
    endtask

    function automatic logic [2:0] ecode(logic [7:0] k);
        ecode = 3'h0;
        for (int i = 2; i < 8; i++) begin
            if (k[i]) begin
                ecode = 3'(i - 1);
            end
        end
    endfunction

    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = plpc_pkg::RESP_OKAY);
        int k;
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (k = 0; k < 20; k++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        if (k == 20) tmo();
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] d, logic [1:0] r = plpc_pkg::RESP_OKAY);
        int k;
        rq.push_back({r, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (k = 0; k < 20; k++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        if (k == 20) tmo();
    endtask

    // Busy spell, optional one-cycle glitch, optional clock-enable gap, then time entry
    task automatic l0s(int g, int k, int e);
        int m;
        @(posedge aclk);
        tx_busy_vc <= 2'($urandom_range(3, 1));
        repeat (2) @(posedge aclk);
        tx_busy_vc <= 2'h0;
        if (g > 0) begin
            repeat (g) @(posedge aclk);
            tx_busy_vc <= 2'($urandom_range(3, 1));
            @(posedge aclk);
            tx_busy_vc <= 2'h0;
        end
        if (k > 0) begin
            aclken <= 1'h0;
            repeat (k) @(posedge aclk);
            aclken <= 1'h1;
        end
        for (m = 0; m < 300 && tx_l0s !== 1'h1; m++) begin
            @(posedge aclk);
        end
        chk("l0s_delay", 34'(m), 34'(e));
        if (m == 300) report_and_stop();
    endtask

    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            chk("rdata", {s_axi_rresp, s_axi_rdata}, rq.size() ? rq.pop_front() : 34'h0);
        end
        if (s_axi_bvalid && s_axi_bready) begin
            chk("bresp", 34'(s_axi_bresp), bq.size() ? 34'(bq.pop_front()) : 34'h0);
        end
        if (cfg_nfts_valid) begin
            chk("nfts", 34'(cfg_nfts), nq.size() ? 34'(nq.pop_front()) : 34'h0);
        end
    end

    initial begin
        void'($urandom(8184));
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        rd(plpc_pkg::ADDR_CTRL, 32'h1);
        rd(plpc_pkg::ADDR_IDLE, 32'h1b);
        rd(plpc_pkg::ADDR_NFTS, 32'hffff);
        rd(plpc_pkg::ADDR_LAT, 32'h0);
        rd(plpc_pkg::ADDR_LINKCAP, 32'({3'h0, ecode(8'hff), 2'h1, 10'h0}));
        s_axi_wstrb <= 4'h2;
        wr(plpc_pkg::ADDR_NFTS, 32'h0000_3c5a);
        s_axi_wstrb <= 4'hf;
        rd(plpc_pkg::ADDR_NFTS, 32'h3cff);
        wr(plpc_pkg::ADDR_DEVCAP, $urandom, plpc_pkg::RESP_SLVERR);
        wr(8'h1c, $urandom, plpc_pkg::RESP_DECERR);
        rd(8'h1c, 32'h0, plpc_pkg::RESP_DECERR);
        rd(plpc_pkg::ADDR_DEVCAP, 32'h0);
        $display("Test registers done");
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            n = 16'($urandom);
            l = 16'($urandom) & 16'h7777;
            rx_pat <= 2'($urandom);
            wr(plpc_pkg::ADDR_CTRL, 32'(c));
            wr(plpc_pkg::ADDR_NFTS, 32'(n));
            wr(plpc_pkg::ADDR_LAT, 32'(l));
            eff = c[1] ? 8'hff : c[0] ? n[7:0] : n[15:8];
            nq.push_back(eff);
            @(posedge aclk) gbl_link_init <= 1'h1;
            @(posedge aclk) gbl_link_init <= 1'h0;
            rd(plpc_pkg::ADDR_CTRL, 32'(c));
            rd(plpc_pkg::ADDR_LAT, 32'(l));
            rd(plpc_pkg::ADDR_DEVCAP, 32'({l[6:4], l[2:0], 6'h0}));
            rd(plpc_pkg::ADDR_LINKCAP, 32'({c[1] ? 3'h7 : c[0] ? l[10:8] : l[14:12],
                ecode(eff), c[2] & !c[1], 1'h1, 10'h0}));
            chk("devcap", 34'(cfg_devcap), 34'({l[6:4], l[2:0], 6'h0}));
            chk("partner_fts", 34'(nfts_seen), 34'(eff));
        end
        $display("Test capabilities done");
        wr(plpc_pkg::ADDR_CTRL, 32'h1);
        wr(plpc_pkg::ADDR_IDLE, 32'h0);
        l0s(5, 0, 9);
        rd(plpc_pkg::ADDR_STATUS, {n[7:0], 14'h0, rx_pat, 7'h0, 1'h1});
        wr(plpc_pkg::ADDR_IDLE, 32'h1f);
        l0s(0, 3, 207);
        v = 5'($urandom);
        wr(plpc_pkg::ADDR_IDLE, 32'(v));
        l0s(0, 0, 2 + ((int'(v) + 1) * 256 + 39) / 40);
        wr(plpc_pkg::ADDR_CTRL, 32'h3);
        wr(plpc_pkg::ADDR_IDLE, 32'h0);
        l0s(0, 0, 207);
        $display("Test idle timer done");
        repeat (4) @(posedge aclk);
        chk("pending", 34'(rq.size() + bq.size() + nq.size()), 34'h0);
        report_and_stop();
    end
endmodule // test_pcie_aspm_link_power_config
